//--- rtl/rx_status_defs.svh
// Register offsets, field positions and limits of the receive status block
`ifndef RX_STATUS_DEFS_SVH
`define RX_STATUS_DEFS_SVH

`define OFS_CTRL 8'h00
`define OFS_STATUS_PORT 8'h04
`define OFS_INFO 8'h08

`define CTRL_RX_EN_BIT 0
`define CTRL_DUMP_BIT 1
`define CTRL_PASS_BAD_BIT 16
`define CTRL_RESET 32'h00000000

`define INFO_ERR_BIT 0
`define INFO_HALTED_BIT 1
`define INFO_LEVEL_LSB 8

`define SW_LEN_LSB 16
`define SW_FILT_FAIL 30
`define SW_SUMMARY 15
`define SW_BCAST 13
`define SW_LEN_MISMATCH 12
`define SW_RUNT 11
`define SW_MCAST 10
`define SW_TOO_LONG 7
`define SW_LATE_COLL 6
`define SW_FTYPE 5
`define SW_WDOG 4
`define SW_MII_ERR 3
`define SW_DRIBBLE 2
`define SW_CRC 1

`define RUNT_BYTES 14'h0040
`define MAX_FRAME_BYTES 14'h05EE
`define MAX_LEN_FIELD 16'h05DC
`define MIN_TYPED_BYTES 14'h000E
`define HDR_CRC_BYTES 17'h00012
`define WDOG_BYTES 14'h0800
`define DRIB_MII_BITS 3'h4
`define DRIB_10M_BITS 3'h3

`endif

//--- rtl/rx_status_pkg.sv
// Types shared by the receive status block
package rx_status_pkg;

  typedef struct packed {
    logic [13:0] length;
    logic [15:0] len_type;
    logic filter_fail;
    logic broadcast;
    logic multicast;
    logic rx_er_seen;
    logic crc_bad;
    logic late_coll;
    logic [2:0] dribble_bits;
    logic speed_10;
  } frame_info_t;

  typedef enum logic [1:0] {
    RX_OFF,
    RX_RUN,
    RX_DRAIN
  } rx_state_t;

endpackage

//--- rtl/status_fifo.sv
// Flip-flop FIFO holding queued receive status words
`timescale 1ns/1ps
module status_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic push,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic pop,
  output logic [WIDTH-1:0] rdata,
  output logic full,
  output logic empty,
  output logic [AW:0] level
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic do_push;
  logic do_pop;

  // Pushes into a full queue and pops from an empty one are dropped
  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  assign full = level == (AW+1)'(DEPTH);
  assign empty = level == '0;
  assign rdata = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      level <= level + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule

//--- rtl/rx_status_ctrl.sv
// Receive status word builder, receiver stop control and APB registers
//
// Overview of operation
// - Reserved status bits 31,14,9:8,0 read zero
// - Bit 30 marks address filter failure
// - Bits 29:16 carry frame length in bytes
// - Bit 15 is OR of 11,7,6,1
// - Bit 13 marks broadcast destination
// - Bit 12 marks length field mismatch
// - Bit 11 marks runt below 64 bytes
// - Runts kept only with pass-bad-frames bit 16
// - Bit 10 marks multicast destination
// - Bit 7 flags over 1518 bytes, no truncation
// - Bit 6 marks late collision
// - Bit 5 type above 1500, never under 14
// - Bit 4 marks receive watchdog expiry
// - Bit 3 marks receive error during frame
// - Bit 2 dribbling: 4 bits MII, 3+ at 10M
// - No dribbling with late collision
// - Bit 1 on CRC error or receive error
// - Pulse halted event once receiver stops
// - Error flag on underruns or status overrun
// - Receiver keeps running after error flag
// - Status pushed only after frame data written
`timescale 1ns/1ps
`include "rx_status_defs.svh"
module rx_status_ctrl
  import rx_status_pkg::*;
#(
  parameter int FIFO_DEPTH = 16,
  parameter logic [13:0] WDOG_LIMIT = `WDOG_BYTES
) (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic FRAME_DONE,
  input wire frame_info_t FRAME_INFO,
  input wire logic DATA_WRITTEN,
  input wire logic FRAME_ACTIVE,
  input wire logic DATA_UNDERRUN,
  output logic RX_ENABLE,
  output logic DISCARD_FRAME,
  output logic RX_HALTED,
  output logic RX_ERROR
);
  localparam int AW = $clog2(FIFO_DEPTH);

  logic [31:0] ctrl;
  rx_state_t state;
  logic [31:0] next_word;
  logic [31:0] pend_word;
  logic pend_valid;
  logic push;
  logic pop;
  logic flush;
  logic [31:0] fifo_rdata;
  logic fifo_full;
  logic fifo_empty;
  logic [AW:0] fifo_level;
  logic acc_first;
  logic acc_done;
  logic wr_done;
  logic runt;
  logic too_long;
  logic late;
  logic crc_err;
  logic keep;
  logic len_mismatch;
  logic dribble;
  logic [16:0] lt_total;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `OFS_CTRL) || (a == `OFS_STATUS_PORT) || (a == `OFS_INFO);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Status word assembly

  assign runt = FRAME_INFO.length < `RUNT_BYTES;
  assign too_long = FRAME_INFO.length > `MAX_FRAME_BYTES;
  assign late = FRAME_INFO.late_coll;
  assign lt_total = 17'(FRAME_INFO.len_type) + `HDR_CRC_BYTES;
  assign crc_err = FRAME_INFO.crc_bad || FRAME_INFO.rx_er_seen;

  always_comb begin
    len_mismatch = 1'b0;
    if (FRAME_INFO.len_type <= `MAX_LEN_FIELD) begin
      // Short frames carry pad bytes, so only an overlong field is wrong
      if (FRAME_INFO.length > `RUNT_BYTES) begin
        len_mismatch = lt_total != 17'(FRAME_INFO.length);
      end else begin
        len_mismatch = lt_total > 17'(FRAME_INFO.length);
      end
    end
  end

  always_comb begin
    if (FRAME_INFO.speed_10) begin
      dribble = FRAME_INFO.dribble_bits >= `DRIB_10M_BITS;
    end else begin
      dribble = FRAME_INFO.dribble_bits == `DRIB_MII_BITS;
    end
  end

  always_comb begin
    next_word = 32'h00000000;
    next_word[`SW_FILT_FAIL] = FRAME_INFO.filter_fail;
    next_word[`SW_LEN_LSB +: 14] = FRAME_INFO.length;
    next_word[`SW_SUMMARY] = runt || too_long || late || crc_err;
    next_word[`SW_BCAST] = FRAME_INFO.broadcast;
    next_word[`SW_LEN_MISMATCH] = len_mismatch;
    next_word[`SW_RUNT] = runt;
    next_word[`SW_MCAST] = FRAME_INFO.multicast;
    next_word[`SW_TOO_LONG] = too_long;
    next_word[`SW_LATE_COLL] = late;
    // type frame, not for short runts
    next_word[`SW_FTYPE] = (FRAME_INFO.len_type > `MAX_LEN_FIELD)
                           && (FRAME_INFO.length >= `MIN_TYPED_BYTES);
    next_word[`SW_WDOG] = FRAME_INFO.length > WDOG_LIMIT;
    next_word[`SW_MII_ERR] = FRAME_INFO.rx_er_seen;
    next_word[`SW_DRIBBLE] = dribble && !late;
    next_word[`SW_CRC] = crc_err;
  end

  assign keep = !runt || ctrl[`CTRL_PASS_BAD_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Pending word and queue push

  // push waits for the data write
  assign push = pend_valid && DATA_WRITTEN;

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      pend_valid <= 1'b0;
      pend_word <= 32'h00000000;
    end else begin
      if (FRAME_DONE && keep) begin
        pend_valid <= 1'b1;
        pend_word <= next_word;
      end else if (push) begin
        pend_valid <= 1'b0;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      DISCARD_FRAME <= 1'b0;
    end else begin
      DISCARD_FRAME <= FRAME_DONE && !keep;
    end
  end

  status_fifo #(
    .WIDTH(32),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(MCLK),
    .rst(SRST),
    .flush(flush),
    .push(push),
    .wdata(pend_word),
    .pop(pop),
    .rdata(fifo_rdata),
    .full(fifo_full),
    .empty(fifo_empty),
    .level(fifo_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, one wait state

  assign acc_first = PSEL && PENABLE && !PREADY;
  assign acc_done = PSEL && PENABLE && PREADY;
  assign wr_done = acc_done && PWRITE;
  assign pop = acc_first && !PWRITE && (PADDR == `OFS_STATUS_PORT);
  // Dump only acts once stopped so no frame is torn
  assign flush = wr_done && (PADDR == `OFS_CTRL) && PWDATA[`CTRL_DUMP_BIT]
                 && (state == RX_OFF);

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h00000000;
    end else begin
      PREADY <= acc_first;
      PSLVERR <= acc_first && !mapped(PADDR);
      if (acc_first && !PWRITE) begin
        case (PADDR)
          `OFS_CTRL: PRDATA <= ctrl;
          `OFS_STATUS_PORT: PRDATA <= fifo_empty ? 32'h00000000 : fifo_rdata;
          `OFS_INFO: begin
            PRDATA <= 32'h00000000;
            PRDATA[`INFO_ERR_BIT] <= RX_ERROR;
            PRDATA[`INFO_HALTED_BIT] <= state == RX_OFF;
            PRDATA[`INFO_LEVEL_LSB +: AW + 1] <= fifo_level;
          end
          default: PRDATA <= 32'h00000000;
        endcase
      end
    end
  end

  // host clears receive enable to halt
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      ctrl <= `CTRL_RESET;
    end else if (wr_done && PADDR == `OFS_CTRL) begin
      ctrl <= PWDATA & ((32'h1 << `CTRL_RX_EN_BIT) | (32'h1 << `CTRL_PASS_BAD_BIT));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver start and stop

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      state <= RX_OFF;
      RX_HALTED <= 1'b0;
    end else begin
      RX_HALTED <= 1'b0;
      case (state)
        RX_OFF: if (ctrl[`CTRL_RX_EN_BIT]) begin
          state <= RX_RUN;
        end
        RX_RUN: if (!ctrl[`CTRL_RX_EN_BIT]) begin
          state <= RX_DRAIN;
        end
        RX_DRAIN: begin
          // single halted pulse after frame ends
          if (!FRAME_ACTIVE && !pend_valid) begin
            state <= RX_OFF;
            RX_HALTED <= 1'b1;
          end
        end
        default: state <= RX_OFF;
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      RX_ENABLE <= 1'b0;
    end else begin
      RX_ENABLE <= ctrl[`CTRL_RX_EN_BIT] && (state != RX_DRAIN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive error flag

  // underruns and status overrun, set beats clear
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      RX_ERROR <= 1'b0;
    end else if (DATA_UNDERRUN || (pop && fifo_empty) || (push && fifo_full)) begin
      RX_ERROR <= 1'b1;
    end else if (wr_done && PADDR == `OFS_INFO && PWDATA[`INFO_ERR_BIT]) begin
      RX_ERROR <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);

  sequence s_drain_begin;
    state == RX_RUN && !ctrl[`CTRL_RX_EN_BIT];
  endsequence

  sequence s_drain_idle;
    state == RX_DRAIN && !FRAME_ACTIVE && !pend_valid;
  endsequence

  a_reserved_zero:
    assert property (push |-> pend_word[31] == 1'b0 && pend_word[14] == 1'b0
                     && pend_word[9:8] == 2'b00 && pend_word[0] == 1'b0)
      else $error("reserved status bit set");
  a_length_field:
    assert property (FRAME_DONE && keep |=> pend_word[29:16] == $past(FRAME_INFO.length))
      else $error("length field wrong");
  a_summary_or:
    assert property (push |-> pend_word[15] == (pend_word[11] | pend_word[7]
                     | pend_word[6] | pend_word[1]))
      else $error("summary bit mismatch");
  a_runt_dropped:
    assert property (FRAME_DONE && runt && !ctrl[`CTRL_PASS_BAD_BIT] && !pend_valid
                     |=> !pend_valid && DISCARD_FRAME)
      else $error("runt not discarded");
  a_short_untyped:
    assert property (FRAME_DONE && keep && FRAME_INFO.length < `MIN_TYPED_BYTES
                     |=> !pend_word[5])
      else $error("type bit on short runt");
  a_dribble_masked:
    assert property (push |-> !(pend_word[2] && pend_word[6]))
      else $error("dribble with late collision");
  a_halt_pulse:
    assert property (s_drain_begin ##1 s_drain_idle |=> RX_HALTED ##1 !RX_HALTED)
      else $error("halted pulse missing");
  a_error_raise:
    assert property (DATA_UNDERRUN || (pop && fifo_empty) |=> RX_ERROR)
      else $error("error flag not raised");
  a_keep_running:
    assert property (state == RX_RUN && ctrl[`CTRL_RX_EN_BIT] && $rose(RX_ERROR)
                     |-> RX_ENABLE [*2])
      else $error("receiver stopped on error");
  a_push_order:
    assert property (u_fifo.level != $past(u_fifo.level) && $past(!pop && !flush)
                     |-> $past(DATA_WRITTEN))
      else $error("status queued before data");
endmodule

//--- testbench/mac_rx_model.sv
// Behavioural model of the MAC receive path feeding the status block
`timescale 1ns/1ps
module mac_rx_model
  import rx_status_pkg::*;
(
  input wire logic clk,
  output logic frame_done,
  output frame_info_t frame_info,
  output logic data_written,
  output logic frame_active,
  output logic data_underrun
);
  initial begin
    frame_done = 1'b0;
    frame_info = '0;
    data_written = 1'b0;
    frame_active = 1'b0;
    data_underrun = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic start();
    @(posedge clk);
    frame_active <= 1'b1;
  endtask

  task automatic finish(input frame_info_t f);
    @(posedge clk);
    frame_active <= 1'b1;
    repeat (2) @(posedge clk);
    frame_active <= 1'b0;
    frame_done <= 1'b1;
    frame_info <= f;
    @(posedge clk);
    frame_done <= 1'b0;
    // Stale info scrambled so nothing leans on it
    frame_info <= ~f;
  endtask

  // data commit comes after frame end
  task automatic commit();
    @(posedge clk);
    data_written <= 1'b1;
    @(posedge clk);
    data_written <= 1'b0;
  endtask

  task automatic underrun();
    @(posedge clk);
    data_underrun <= 1'b1;
    @(posedge clk);
    data_underrun <= 1'b0;
  endtask
endmodule

//--- testbench/tb.sv
// Self-checking bench for the receive status block
`timescale 1ns/1ps
`include "rx_status_defs.svh"
module tb;
  import rx_status_pkg::*;
  logic MCLK, SRST, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic frame_done, data_written, frame_active, data_underrun;
  logic rx_enable, discard_frame, rx_halted, rx_error;
  frame_info_t frame_info;
  frame_info_t fr [6];
  int bad_count = 0;
  int compares = 0;
  int halts = 0;
  int cycles = 0;

  rx_status_ctrl dut (.MCLK(MCLK), .SRST(SRST), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .FRAME_DONE(frame_done), .FRAME_INFO(frame_info),
    .DATA_WRITTEN(data_written), .FRAME_ACTIVE(frame_active),
    .DATA_UNDERRUN(data_underrun), .RX_ENABLE(rx_enable), .DISCARD_FRAME(discard_frame),
    .RX_HALTED(rx_halted), .RX_ERROR(rx_error));

  mac_rx_model mac (.clk(MCLK), .frame_done(frame_done), .frame_info(frame_info),
    .data_written(data_written), .frame_active(frame_active),
    .data_underrun(data_underrun));

  initial begin
    MCLK = 1'b0;
    forever #50 MCLK = ~MCLK;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge MCLK) begin
    cycles <= cycles + 1;
    if (rx_halted === 1'b1) halts <= halts + 1;
    if (cycles == 5000) begin
      bad_count++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until the edge that samples pready high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge MCLK);
    penable <= 1'b1;
    @(posedge MCLK);
    while (pready !== 1'b1) @(posedge MCLK);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] exp_word(frame_info_t f);
    logic [31:0] w;
    logic [16:0] hl;
    w = 32'h0;
    hl = {1'b0, f.len_type} + 17'h00012;
    w[30] = f.filter_fail;
    w[29:16] = f.length;
    w[13] = f.broadcast;
    w[12] = f.len_type <= 1500 && (f.length > 64 ? hl != f.length : hl > f.length);
    w[11] = f.length < 64;
    w[10] = f.multicast;
    w[7] = f.length > 1518;
    w[6] = f.late_coll;
    w[5] = f.len_type > 1500 && f.length >= 14;
    w[4] = f.length > 2048;
    w[3] = f.rx_er_seen;
    w[2] = !f.late_coll && (f.speed_10 ? f.dribble_bits >= 3 : f.dribble_bits == 4);
    w[1] = f.crc_bad | f.rx_er_seen;
    w[15] = w[11] | w[7] | w[6] | w[1];
    return w;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  initial begin
    SRST = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fr = '{'{14'd100, 16'd82, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 3'd0, 1'b0},
      '{14'd1600, 16'h0800, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 3'd4, 1'b0},
      '{14'd2100, 16'h0800, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 3'd4, 1'b0},
      '{14'd10, 16'h0800, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'd0, 1'b0},
      '{14'd64, 16'd40, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 3'd3, 1'b1},
      '{14'd1518, 16'd1500, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'd3, 1'b0}};
    repeat (8) @(posedge MCLK);
    SRST <= 1'b0;
    @(negedge MCLK);
    chk({rx_enable, rx_halted, rx_error, discard_frame}, 32'h0);
    apb(0, `OFS_CTRL, 32'h0);
    chk(q, 32'h0);
    apb(1, `OFS_CTRL, 32'h00010003);
    apb(0, `OFS_CTRL, 32'h0);
    chk(q, 32'h00010001);
    chk(rx_enable, 32'h1);
    foreach (fr[i]) begin
      mac.finish(fr[i]);
      repeat (3) @(posedge MCLK);
      apb(0, `OFS_INFO, 32'h0);
      chk(q[15:8], 32'h0);
      mac.commit();
      apb(0, `OFS_STATUS_PORT, 32'h0);
      chk(q, exp_word(fr[i]));
    end
    // Runt dropped once bad frames are not passed
    apb(1, `OFS_CTRL, 32'h00000001);
    mac.finish(fr[3]);
    @(negedge MCLK);
    chk(discard_frame, 32'h1);
    mac.commit();
    apb(0, `OFS_INFO, 32'h0);
    chk(q[15:8], 32'h0);
    repeat (17) begin
      mac.finish(fr[0]);
      mac.commit();
    end
    apb(0, `OFS_INFO, 32'h0);
    chk(q[15:0], 32'h1001);
    chk(rx_enable, 32'h1);
    apb(1, `OFS_INFO, 32'h1);
    repeat (16) begin
      apb(0, `OFS_STATUS_PORT, 32'h0);
      chk(q, exp_word(fr[0]));
    end
    chk(rx_error, 32'h0);
    apb(0, `OFS_STATUS_PORT, 32'h0);
    repeat (2) @(negedge MCLK);
    chk(q, 32'h0);
    chk(rx_error, 32'h1);
    apb(1, `OFS_INFO, 32'h1);
    repeat (2) @(negedge MCLK);
    chk(rx_error, 32'h0);
    mac.underrun();
    repeat (2) @(negedge MCLK);
    chk(rx_error, 32'h1);
    apb(0, 8'h0C, 32'h0);
    chk(q, 32'h0);
    chk(err, 32'h1);
    // Soft reset clears the underrun error flag and returns the block to halted
    @(posedge MCLK);
    SRST <= 1'b1;
    repeat (2) @(posedge MCLK);
    SRST <= 1'b0;
    @(negedge MCLK);
    chk({rx_enable, rx_halted, rx_error, discard_frame}, 32'h0);
    apb(0, `OFS_INFO, 32'h0);
    chk(q, 32'h00000002);
    apb(1, `OFS_CTRL, 32'h00000001);
    // Halt requested mid-frame must wait for the frame
    mac.start();
    apb(1, `OFS_CTRL, 32'h0);
    repeat (5) @(negedge MCLK);
    chk(halts, 32'h0);
    chk(rx_enable, 32'h0);
    mac.finish(fr[0]);
    mac.commit();
    repeat (10) @(negedge MCLK);
    chk(halts, 32'h1);
    apb(0, `OFS_INFO, 32'h0);
    chk(q[15:1], 32'h0081);
    apb(1, `OFS_CTRL, 32'h2);
    apb(0, `OFS_INFO, 32'h0);
    chk(q[15:8], 32'h0);
    apb(1, `OFS_CTRL, 32'h1);
    apb(0, `OFS_INFO, 32'h0);
    chk(q[1], 32'h0);
    chk(rx_enable, 32'h1);
    // Halt with no frame in flight stops at once
    apb(1, `OFS_CTRL, 32'h0);
    repeat (4) @(negedge MCLK);
    chk(halts, 32'h2);
    chk(rx_enable, 32'h0);
    test_done();
  end
endmodule
